// ===== core/lfsc_core.v
// Linefeed supervision and control for one telephone line channel.
// Assumes a host on a plain strobe register port in the CLK_I domain and
// asynchronous analogue fault and detector comparators on its pins.
`timescale 1ns/1ns
`include "lfsc_defs.vh"

module lfsc_core #(
  parameter DATA_W = 16,
  parameter RESTART_CYC = ((`LFSC_RESTART_NS + `LFSC_CLK_NS - 1) / `LFSC_CLK_NS)
) (
  // Clock and reset
  input wire CLK_I,
  input wire ARST_N_I,
  // Register port
  input wire [3:0] ADDR_I,
  input wire [15:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [15:0] RDATA_O,
  // Analogue fault comparators (asynchronous)
  input wire PWR_OVER_I,
  input wire FOREIGN_V_I,
  input wire TEMP_145_I,
  input wire TEMP_200_I,
  // Measured loop and longitudinal currents, already quasi-static codes
  input wire [15:0] LOOP_I_I,
  input wire [15:0] LONG_I_I,
  // DTMF front end: row and column tone presence (asynchronous)
  input wire [3:0] DTMF_ROW_I,
  input wire [3:0] DTMF_COL_I,
  // Linefeed driver controls
  output reg [2:0] LF_STATE_O,
  output reg TIP_OE_O,
  output reg RING_OE_O,
  output reg FWD_POL_O,
  output reg AUDIO_EN_O,
  output reg SUPV_EN_O,
  output reg DIAG_EN_O,
  output reg LOWPWR_O,
  output reg RING_EN_O,
  output reg RING_DC_EN_O,
  output reg [1:0] RING_MODE_O,
  output reg RING_TRAP_O,
  output reg [15:0] RING_FREQ_O,
  output reg [7:0] POL_RAMP_O,
  // Tone generators
  output reg [15:0] TONE0_CFG_O,
  output reg [15:0] TONE1_CFG_O,
  output reg [1:0] TONE_EN_O,
  output reg TONE_TO_TX_O,
  // Interrupt request level
  output reg IRQ_O
);

  // Synchronisers: stage one feeds stage two only
  reg [3:0] flt_s1_reg, flt_s2_reg;
  reg [7:0] dt_s1_reg, dt_s2_reg;
  always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      flt_s1_reg <= 4'h0;
      flt_s2_reg <= 4'h0;
      dt_s1_reg <= 8'h00;
      dt_s2_reg <= 8'h00;
    end else begin
      flt_s1_reg <= {TEMP_200_I, TEMP_145_I, FOREIGN_V_I, PWR_OVER_I};
      flt_s2_reg <= flt_s1_reg;
      dt_s1_reg <= {DTMF_ROW_I, DTMF_COL_I};
      dt_s2_reg <= dt_s1_reg;
    end
  end
  // Current codes are sampled through two stages as well
  reg [15:0] li_s1_reg, li_s2_reg, gi_s1_reg, gi_s2_reg;
  always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      li_s1_reg <= 16'h0000;
      li_s2_reg <= 16'h0000;
      gi_s1_reg <= 16'h0000;
      gi_s2_reg <= 16'h0000;
    end else begin
      li_s1_reg <= LOOP_I_I;
      li_s2_reg <= li_s1_reg;
      gi_s1_reg <= LONG_I_I;
      gi_s2_reg <= gi_s1_reg;
    end
  end

  // Host registers
  reg [2:0] state_reg;          // Selected linefeed state
  reg [3:0] mask_reg;           // Interrupt enables
  reg [3:0] irq_reg;            // Sticky flags, write one to clear
  reg [15:0] lc_thr_reg;        // [15:8] on threshold, [7:0] off threshold
  reg [15:0] gk_thr_reg;
  reg [15:0] deb_reg;           // [15:8] loop debounce, [7:0] ground key debounce
  reg [15:0] ring_reg;          // [1:0] mode, [2] trapezoid, [3] dc on, [15:8] held for readback only
  reg [15:0] ring_frq_reg;
  reg [15:0] ring_cad_reg;      // [15:8] on time, [7:0] off time, ticks of 256 clocks
  reg [7:0] pol_reg;            // Ramp rate, zero is abrupt
  reg [15:0] tone0_reg, tone1_reg;
  reg [2:0] tone_ctl_reg;       // [1:0] enables, [2] route to transmit
  reg therm_sel_reg;            // 0 selects 145, 1 selects 200
  reg diag_reg;                 // Diagnostic test resources when state code 7 and set
  // Detector state
  reg lc_reg, gk_reg;           // Debounced status
  reg lc_raw_reg, gk_raw_reg;   // Hysteresis comparator outputs
  reg [7:0] lc_cnt_reg, gk_cnt_reg;
  reg [3:0] dtmf_digit_reg;
  reg dtmf_valid_reg;
  // Thermal hold
  reg therm_hold_reg;
  reg [31:0] therm_cnt_reg;
  // Cadence
  reg [7:0] cad_pre_reg;
  reg [7:0] cad_cnt_reg;
  reg cad_on_reg;

  // Decode of a one-hot tone group to its index; other patterns are invalid
  function [2:0] onehot4;
    input [3:0] v;
    begin
      case (v)
        4'h1: onehot4 = 3'h4;
        4'h2: onehot4 = 3'h5;
        4'h4: onehot4 = 3'h6;
        4'h8: onehot4 = 3'h7;
        default: onehot4 = 3'h0;
      endcase
    end
  endfunction

  // Hysteresis comparator: set at or above on, clear at or below off
  function hyst;
    input prev;
    input [15:0] val;
    input [15:0] thr;
    begin
      if (val[15:8] != 8'h00 && val >= {8'h00, thr[15:8]} << 8)
        hyst = 1'b1;
      else if (val <= {8'h00, thr[7:0]} << 8)
        hyst = 1'b0;
      else
        hyst = prev;
    end
  endfunction

  wire wr_state = WR_I && (ADDR_I == `LFSC_A_STATE);
  wire therm_trip = therm_sel_reg ? flt_s2_reg[3] : flt_s2_reg[2];
  wire fault = flt_s2_reg[0] | flt_s2_reg[1] | therm_trip | therm_hold_reg;
  wire det_on = (state_reg == `LFSC_ST_FWD_ACT) || (state_reg == `LFSC_ST_REV_ACT) ||
                (state_reg == `LFSC_ST_TIP_OPEN) || (state_reg == `LFSC_ST_RNG_OPEN && !diag_reg);
  wire lc_next = hyst(lc_raw_reg, li_s2_reg, lc_thr_reg);
  wire gk_next = hyst(gk_raw_reg, gi_s2_reg, gk_thr_reg);
  wire lc_chg = det_on && (lc_cnt_reg >= deb_reg[15:8]) && (lc_raw_reg != lc_reg);
  wire gk_chg = det_on && (gk_cnt_reg >= deb_reg[7:0]) && (gk_raw_reg != gk_reg);
  wire [2:0] row_code = onehot4(dt_s2_reg[7:4]);
  wire [2:0] col_code = onehot4(dt_s2_reg[3:0]);
  wire dtmf_hit = row_code[2] && col_code[2] && !dtmf_valid_reg;
  wire [3:0] set_vec = {dtmf_hit, fault && state_reg != `LFSC_ST_OPEN, gk_chg, lc_chg};

  // Thermal shutdown holds until the sensor is clear for the restart delay
  always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      therm_hold_reg <= 1'b0;
      therm_cnt_reg <= 32'h0;
    end else if (therm_trip) begin
      therm_hold_reg <= 1'b1;
      therm_cnt_reg <= 32'h0;
    end else if (therm_hold_reg) begin
      if (therm_cnt_reg >= RESTART_CYC - 1)
        therm_hold_reg <= 1'b0;
      therm_cnt_reg <= therm_cnt_reg + 32'h1;
    end
  end

  // Host writes and fault-driven state
  always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_reg <= `LFSC_ST_OPEN;
      mask_reg <= 4'h0;
      lc_thr_reg <= `LFSC_THR_RST;
      gk_thr_reg <= `LFSC_THR_RST;
      deb_reg <= `LFSC_DEB_RST;
      ring_reg <= 16'h0000;
      ring_frq_reg <= 16'h0000;
      ring_cad_reg <= 16'h0000;
      pol_reg <= 8'h00;
      tone0_reg <= 16'h0000;
      tone1_reg <= 16'h0000;
      tone_ctl_reg <= 3'h0;
      therm_sel_reg <= 1'b0;
      diag_reg <= 1'b0;
    end else begin
      if (fault)
        state_reg <= `LFSC_ST_OPEN;
      else if (wr_state)
        state_reg <= WDATA_I[2:0];
      if (WR_I) begin
        case (ADDR_I)
          `LFSC_A_STATE: diag_reg <= WDATA_I[3];
          `LFSC_A_MASK: mask_reg <= WDATA_I[3:0];
          `LFSC_A_LC_THR: lc_thr_reg <= WDATA_I;
          `LFSC_A_GK_THR: gk_thr_reg <= WDATA_I;
          `LFSC_A_DEB: deb_reg <= WDATA_I;
          `LFSC_A_RING: ring_reg <= WDATA_I;
          `LFSC_A_RING_FRQ: ring_frq_reg <= WDATA_I;
          `LFSC_A_RING_CAD: ring_cad_reg <= WDATA_I;
          `LFSC_A_POL: pol_reg <= WDATA_I[7:0];
          `LFSC_A_TONE0: tone0_reg <= WDATA_I;
          `LFSC_A_TONE1: tone1_reg <= WDATA_I;
          `LFSC_A_TONE_CTL: tone_ctl_reg <= WDATA_I[2:0];
          `LFSC_A_THERM: therm_sel_reg <= WDATA_I[0];
          default: ;
        endcase
      end
    end
  end
  // Sticky flags; a set in the clearing cycle wins
  always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I)
      irq_reg <= 4'h0;
    else if (WR_I && ADDR_I == `LFSC_A_IRQ)
      irq_reg <= (irq_reg & ~WDATA_I[3:0]) | set_vec;
    else
      irq_reg <= irq_reg | set_vec;
  end
  // Detectors: hysteresis, then debounce counting on a steady raw value
  always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      lc_raw_reg <= 1'b0;
      gk_raw_reg <= 1'b0;
      lc_cnt_reg <= 8'h00;
      gk_cnt_reg <= 8'h00;
      lc_reg <= 1'b0;
      gk_reg <= 1'b0;
    end else if (!det_on) begin
      // Supervision powered down: report idle
      lc_raw_reg <= 1'b0;
      gk_raw_reg <= 1'b0;
      lc_cnt_reg <= 8'h00;
      gk_cnt_reg <= 8'h00;
      lc_reg <= 1'b0;
      gk_reg <= 1'b0;
    end else begin
      lc_raw_reg <= lc_next;
      gk_raw_reg <= gk_next;
      if (lc_next != lc_raw_reg || lc_raw_reg == lc_reg)
        lc_cnt_reg <= 8'h00;
      else if (lc_cnt_reg != 8'hff)
        lc_cnt_reg <= lc_cnt_reg + 8'h01;
      if (gk_next != gk_raw_reg || gk_raw_reg == gk_reg)
        gk_cnt_reg <= 8'h00;
      else if (gk_cnt_reg != 8'hff)
        gk_cnt_reg <= gk_cnt_reg + 8'h01;
      if (lc_chg)
        lc_reg <= lc_raw_reg;
      if (gk_chg)
        gk_reg <= gk_raw_reg;
    end
  end

  // DTMF: one row and one column present gives one of sixteen digits
  always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      dtmf_digit_reg <= 4'h0;
      dtmf_valid_reg <= 1'b0;
    end else if (dtmf_hit) begin
      dtmf_digit_reg <= {row_code[1:0], col_code[1:0]};
      dtmf_valid_reg <= 1'b1;
    end else if (!(row_code[2] && col_code[2])) begin
      dtmf_valid_reg <= 1'b0;
    end
  end

  // Ringing cadence: on and off times in ticks of 256 clocks
  always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cad_pre_reg <= 8'h00;
      cad_cnt_reg <= 8'h00;
      cad_on_reg <= 1'b1;
    end else if (state_reg != `LFSC_ST_RINGING) begin
      cad_pre_reg <= 8'h00;
      cad_cnt_reg <= 8'h00;
      cad_on_reg <= 1'b1;
    end else begin
      cad_pre_reg <= cad_pre_reg + 8'h01;
      if (cad_pre_reg == 8'hff) begin
        if (cad_cnt_reg >= (cad_on_reg ? ring_cad_reg[15:8] : ring_cad_reg[7:0])) begin
          cad_cnt_reg <= 8'h00;
          cad_on_reg <= ~cad_on_reg | (ring_cad_reg[7:0] == 8'h00);
        end else begin
          cad_cnt_reg <= cad_cnt_reg + 8'h01;
        end
      end
    end
  end

  // Driver controls decoded from the linefeed state; ring settings, tones and interrupt level registered from the registers
  always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      LF_STATE_O <= `LFSC_ST_OPEN;
      TIP_OE_O <= 1'b0;
      RING_OE_O <= 1'b0;
      FWD_POL_O <= 1'b1;
      AUDIO_EN_O <= 1'b0;
      SUPV_EN_O <= 1'b0;
      DIAG_EN_O <= 1'b0;
      LOWPWR_O <= 1'b0;
      RING_EN_O <= 1'b0;
      RING_DC_EN_O <= 1'b0;
      RING_MODE_O <= `LFSC_RM_BAL;
      RING_TRAP_O <= 1'b0;
      RING_FREQ_O <= 16'h0000;
      POL_RAMP_O <= 8'h00;
      TONE0_CFG_O <= 16'h0000;
      TONE1_CFG_O <= 16'h0000;
      TONE_EN_O <= 2'h0;
      TONE_TO_TX_O <= 1'b0;
      IRQ_O <= 1'b0;
    end else begin
      LF_STATE_O <= state_reg;
      TIP_OE_O <= (state_reg != `LFSC_ST_OPEN) && (state_reg != `LFSC_ST_TIP_OPEN) &&
                  !(state_reg == `LFSC_ST_RNG_OPEN && diag_reg);
      RING_OE_O <= (state_reg != `LFSC_ST_OPEN) && (state_reg != `LFSC_ST_RNG_OPEN);
      FWD_POL_O <= !(state_reg == `LFSC_ST_REV_ACT || state_reg == `LFSC_ST_REV_OHT ||
                     (state_reg == `LFSC_ST_RNG_OPEN && !diag_reg));
      AUDIO_EN_O <= (state_reg == `LFSC_ST_FWD_ACT) || (state_reg == `LFSC_ST_REV_ACT) ||
                    (state_reg == `LFSC_ST_FWD_OHT) || (state_reg == `LFSC_ST_REV_OHT);
      SUPV_EN_O <= det_on;
      DIAG_EN_O <= (state_reg == `LFSC_ST_DIAG) && diag_reg;
      LOWPWR_O <= therm_trip | therm_hold_reg;
      RING_EN_O <= (state_reg == `LFSC_ST_RINGING) && cad_on_reg;
      RING_DC_EN_O <= (state_reg == `LFSC_ST_RINGING) && ring_reg[3];
      RING_MODE_O <= ring_reg[1:0];
      RING_TRAP_O <= ring_reg[2];
      RING_FREQ_O <= ring_frq_reg;
      POL_RAMP_O <= pol_reg;
      TONE0_CFG_O <= tone0_reg;
      TONE1_CFG_O <= tone1_reg;
      TONE_EN_O <= tone_ctl_reg[1:0];
      TONE_TO_TX_O <= tone_ctl_reg[2];
      IRQ_O <= |(irq_reg & mask_reg);
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I)
      RDATA_O <= 16'h0000;
    else if (!RD_I)
      RDATA_O <= 16'h0000;
    else begin
      case (ADDR_I)
        `LFSC_A_STATE: RDATA_O <= {12'h000, diag_reg, state_reg};
        `LFSC_A_STATUS: RDATA_O <= {7'h00, dtmf_valid_reg, dtmf_digit_reg, therm_hold_reg,
                                    fault, gk_reg, lc_reg};
        `LFSC_A_IRQ: RDATA_O <= {12'h000, irq_reg};
        `LFSC_A_MASK: RDATA_O <= {12'h000, mask_reg};
        `LFSC_A_LC_THR: RDATA_O <= lc_thr_reg;
        `LFSC_A_GK_THR: RDATA_O <= gk_thr_reg;
        `LFSC_A_DEB: RDATA_O <= deb_reg;
        `LFSC_A_RING: RDATA_O <= ring_reg;
        `LFSC_A_RING_FRQ: RDATA_O <= ring_frq_reg;
        `LFSC_A_RING_CAD: RDATA_O <= ring_cad_reg;
        `LFSC_A_POL: RDATA_O <= {8'h00, pol_reg};
        `LFSC_A_TONE0: RDATA_O <= tone0_reg;
        `LFSC_A_TONE1: RDATA_O <= tone1_reg;
        `LFSC_A_TONE_CTL: RDATA_O <= {13'h0000, tone_ctl_reg};
        `LFSC_A_DTMF: RDATA_O <= {11'h000, dtmf_valid_reg, dtmf_digit_reg};
        default: RDATA_O <= {15'h0000, therm_sel_reg};
      endcase
    end
  end

endmodule // lfsc_core

// ===== core/lfsc_defs.vh
// Constants for the linefeed supervision and control block.
// Included by the design file; holds definitions only.
`ifndef LFSC_DEFS_VH
`define LFSC_DEFS_VH

// Register indices (word address on the plain register port)
`define LFSC_A_STATE     4'h0
`define LFSC_A_STATUS    4'h1
`define LFSC_A_IRQ       4'h2
`define LFSC_A_MASK      4'h3
`define LFSC_A_LC_THR    4'h4
`define LFSC_A_GK_THR    4'h5
`define LFSC_A_DEB       4'h6
`define LFSC_A_RING      4'h7
`define LFSC_A_RING_FRQ  4'h8
`define LFSC_A_RING_CAD  4'h9
`define LFSC_A_POL       4'ha
`define LFSC_A_TONE0     4'hb
`define LFSC_A_TONE1     4'hc
`define LFSC_A_TONE_CTL  4'hd
`define LFSC_A_DTMF      4'he
`define LFSC_A_THERM     4'hf

// Linefeed states (3-bit code)
`define LFSC_ST_OPEN     3'h0
`define LFSC_ST_FWD_ACT  3'h1
`define LFSC_ST_FWD_OHT  3'h2
`define LFSC_ST_TIP_OPEN 3'h3
`define LFSC_ST_RINGING  3'h4
`define LFSC_ST_REV_ACT  3'h5
`define LFSC_ST_REV_OHT  3'h6
`define LFSC_ST_RNG_OPEN 3'h7
`define LFSC_ST_DIAG     3'h7

// Interrupt bit positions; the status register shares bits 0 to 2 only (status bit 3 is thermal hold)
`define LFSC_B_LC        0
`define LFSC_B_GK        1
`define LFSC_B_PWR       2
`define LFSC_B_DTMF      3

// Ringing mode codes
`define LFSC_RM_BAL      2'h0
`define LFSC_RM_UNBAL    2'h1
`define LFSC_RM_LOWPWR   2'h2

// Reset values, thermal restart delay and clock period
`define LFSC_DEB_RST     16'h0010
`define LFSC_THR_RST     16'h0000
`define LFSC_RESTART_NS  1000000
`define LFSC_CLK_NS      8

`endif

// ===== verif/lfsc_core_monitor.sv
// Port-level checker for the linefeed supervision and control core.
// Assumes one clock domain and the asynchronous active-low reset of the core.
`timescale 1ns/1ns
module lfsc_core_monitor (
  // Clock and reset
  input wire CLK_I,
  input wire ARST_N_I,
  // Host port and fault pins
  input wire [3:0] ADDR_I,
  input wire WR_I,
  input wire RD_I,
  input wire [15:0] RDATA_O,
  input wire PWR_OVER_I,
  input wire FOREIGN_V_I,
  // Linefeed driver controls
  input wire [2:0] LF_STATE_O,
  input wire TIP_OE_O,
  input wire RING_OE_O,
  input wire FWD_POL_O,
  input wire AUDIO_EN_O,
  input wire SUPV_EN_O,
  input wire DIAG_EN_O,
  input wire LOWPWR_O,
  input wire RING_EN_O
);
  // Host write to the state register
  wire st_wr = WR_I && ADDR_I == 4'h0;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  // Read data stands only in the cycle after a read strobe
  a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 16'h0)
    else $error("read data outside read cycle");
  // Held state decodes tolerate one cycle of output skew
  a_open_hiz: assert property (LF_STATE_O == 3'h0 && $stable(LF_STATE_O) |->
    !TIP_OE_O && !RING_OE_O && !AUDIO_EN_O && !SUPV_EN_O) else $error("open state drives line");
  a_fault_open: assert property ((PWR_OVER_I || FOREIGN_V_I) [*6] |-> LF_STATE_O == 3'h0)
    else $error("fault did not open line");
  a_stay_open: assert property (LF_STATE_O == 3'h0 && !st_wr && !$past(st_wr) && !$past(st_wr, 2)
    |=> LF_STATE_O == 3'h0) else $error("left open without host write");
  a_tip_open: assert property (LF_STATE_O == 3'h3 && $stable(LF_STATE_O) |->
    !TIP_OE_O && RING_OE_O && SUPV_EN_O) else $error("tip-open lead drive wrong");
  a_ring_open: assert property (LF_STATE_O == 3'h7 && $stable(LF_STATE_O) && !DIAG_EN_O &&
    !$past(DIAG_EN_O) |-> TIP_OE_O && !RING_OE_O && SUPV_EN_O && !FWD_POL_O)
    else $error("ring-open lead drive wrong");
  a_fwd_pol: assert property (LF_STATE_O inside {3'h1, 3'h2} && $stable(LF_STATE_O) |->
    FWD_POL_O && AUDIO_EN_O && TIP_OE_O && RING_OE_O) else $error("forward polarity wrong");
  a_rev_pol: assert property (LF_STATE_O inside {3'h5, 3'h6} && $stable(LF_STATE_O) |->
    !FWD_POL_O && AUDIO_EN_O) else $error("reverse polarity wrong");
  a_ring_only: assert property (LF_STATE_O != 3'h4 && $past(LF_STATE_O) != 3'h4 |-> !RING_EN_O)
    else $error("ringing outside ringing state");
  a_diag_only: assert property (LF_STATE_O != 3'h7 && $past(LF_STATE_O) != 3'h7 |-> !DIAG_EN_O)
    else $error("diagnostics outside code seven");
  a_lowpwr_open: assert property (LOWPWR_O && $past(LOWPWR_O) && $past(LOWPWR_O, 2) |->
    LF_STATE_O == 3'h0) else $error("shutdown without open state");
  // Main scenarios reached
  c_ring: cover property (LF_STATE_O == 3'h4 && RING_EN_O);
  c_diag: cover property (DIAG_EN_O);
  c_fault: cover property (PWR_OVER_I ##6 LF_STATE_O == 3'h0);
endmodule // lfsc_core_monitor

bind lfsc_core lfsc_core_monitor u_mon (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .ADDR_I(ADDR_I), .WR_I(WR_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .PWR_OVER_I(PWR_OVER_I), .FOREIGN_V_I(FOREIGN_V_I),
  .LF_STATE_O(LF_STATE_O), .TIP_OE_O(TIP_OE_O), .RING_OE_O(RING_OE_O), .FWD_POL_O(FWD_POL_O),
  .AUDIO_EN_O(AUDIO_EN_O), .SUPV_EN_O(SUPV_EN_O), .DIAG_EN_O(DIAG_EN_O), .LOWPWR_O(LOWPWR_O),
  .RING_EN_O(RING_EN_O));

// ===== verif/lfsc_line_model.sv
// Behavioural stand-in for the analogue line and its comparators.
// Assumes the bench sets the line condition; outputs are quasi-static levels.
`timescale 1ns/1ns
module lfsc_line_model (
  // Line condition set by the bench
  input wire logic [15:0] loop_code_i,
  input wire logic [15:0] long_code_i,
  input wire logic tone_on_i,
  input wire logic [1:0] row_i,
  input wire logic [1:0] col_i,
  input wire logic [3:0] fault_i,
  // Toward the core
  output logic pwr_over_o,
  output logic foreign_v_o,
  output logic temp_145_o,
  output logic temp_200_o,
  output logic [15:0] loop_i_o,
  output logic [15:0] long_i_o,
  output logic [3:0] row_o,
  output logic [3:0] col_o
);
  // Fault comparators: total power, foreign voltage, two thermal sensors
  assign {temp_200_o, temp_145_o, foreign_v_o, pwr_over_o} = fault_i;
  // Currents move slowly, so a plain level is a fair picture
  assign loop_i_o = loop_code_i;
  assign long_i_o = long_code_i;
  // One row tone and one column tone per digit; silence shows no tone at all
  assign row_o = tone_on_i ? 4'h1 << row_i : 4'h0;
  assign col_o = tone_on_i ? 4'h1 << col_i : 4'h0;
endmodule // lfsc_line_model

// ===== verif/tb_lfsc_core.sv
// Self-checking bench for lfsc_core: states, ringing, tones, faults, detectors, digits.
// Assumes the checker is bound to the core and the line model drives the analogue pins.
`timescale 1ns/1ns
`include "lfsc_defs.vh"
`define LFSC_CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_lfsc_core;
  // Host port and line condition, all driven by the bench
  logic clk = 0, arst_n = 0, wr = 0, rd = 0, tone_on = 0;
  logic [3:0] addr = 4'h0, fault = 4'h0;
  logic [15:0] wdata = 16'h0, rd_val, loop_code = 16'h0, long_code = 16'h0;
  logic [1:0] row = 2'h0, col = 2'h0;
  // Pins between model and core, and core outputs
  wire pwr, fvolt, t145, t200, tip_oe, ring_oe, fwd_pol, audio_en, supv_en, diag_en, lowpwr;
  wire ring_en, ring_dc, ring_trap, tone_tx, irq;
  wire [15:0] rdata, loop_i, long_i, ring_freq, tone0, tone1;
  wire [3:0] drow, dcol;
  wire [2:0] lf_state;
  wire [7:0] pol_ramp;
  wire [1:0] ring_mode, tone_en;
  // Lead drive per state code: bit n is the expectation for code n
  localparam logic [7:0] tip_map = 8'hf6, ring_map = 8'h7e, supv_map = 8'haa, fwd_map = 8'h1f;
  int n_errors = 0, n_checks = 0, cyc = 0;
  always #4 clk = ~clk;
  // Short thermal restart delay keeps the run brief
  lfsc_core #(.RESTART_CYC(8)) uut (.CLK_I(clk), .ARST_N_I(arst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PWR_OVER_I(pwr), .FOREIGN_V_I(fvolt), .TEMP_145_I(t145),
    .TEMP_200_I(t200), .LOOP_I_I(loop_i), .LONG_I_I(long_i), .DTMF_ROW_I(drow), .DTMF_COL_I(dcol),
    .LF_STATE_O(lf_state), .TIP_OE_O(tip_oe), .RING_OE_O(ring_oe), .FWD_POL_O(fwd_pol),
    .AUDIO_EN_O(audio_en), .SUPV_EN_O(supv_en), .DIAG_EN_O(diag_en), .LOWPWR_O(lowpwr),
    .RING_EN_O(ring_en), .RING_DC_EN_O(ring_dc), .RING_MODE_O(ring_mode), .RING_TRAP_O(ring_trap),
    .RING_FREQ_O(ring_freq), .POL_RAMP_O(pol_ramp), .TONE0_CFG_O(tone0), .TONE1_CFG_O(tone1),
    .TONE_EN_O(tone_en), .TONE_TO_TX_O(tone_tx), .IRQ_O(irq));
  lfsc_line_model u_line (.loop_code_i(loop_code), .long_code_i(long_code), .tone_on_i(tone_on),
    .row_i(row), .col_i(col), .fault_i(fault), .pwr_over_o(pwr), .foreign_v_o(fvolt),
    .temp_145_o(t145), .temp_200_o(t200), .loop_i_o(loop_i), .long_i_o(long_i), .row_o(drow), .col_o(dcol));
  // Wait n edges, then step past the edge so outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One-cycle write strobe
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // One-cycle read strobe; data is taken in the following cycle only
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 rd_val = rdata;
  endtask
  // Move one measured current at a clock edge
  task automatic drive(input int g, input logic [15:0] v);
    @(posedge clk);
    if (g) long_code <= v;
    else loop_code <= v;
  endtask
  task automatic t_reset();
    tick(1);
    `LFSC_CHK("reset_state", 3'h0, lf_state)
    `LFSC_CHK("reset_drive", 5'h10, {fwd_pol, tip_oe, ring_oe, audio_en, supv_en})
    rd_reg(`LFSC_A_STATE);
    `LFSC_CHK("state_reg", 16'h0, rd_val)
    $display("t_reset done");
  endtask
  // Every state code in turn, ending back in open
  task automatic t_states();
    for (int s = 1; s <= 8; s++) begin
      wr_reg(`LFSC_A_STATE, 16'(s % 8));
      tick(3);
      `LFSC_CHK("lf_state", 3'(s % 8), lf_state)
      `LFSC_CHK("tip_oe", tip_map[s % 8], tip_oe)
      `LFSC_CHK("ring_oe", ring_map[s % 8], ring_oe)
      `LFSC_CHK("supv_en", supv_map[s % 8], supv_en)
      `LFSC_CHK("diag_en", 1'b0, diag_en)
      `LFSC_CHK("fwd_pol", fwd_map[s % 8], fwd_pol)
      if (s % 4 == 1 || s % 4 == 2) begin
        `LFSC_CHK("audio_en", 1'b1, audio_en)
      end
    end
    `LFSC_CHK("open_audio", 1'b0, audio_en)
    wr_reg(`LFSC_A_STATE, 16'h000f);
    tick(3);
    `LFSC_CHK("diag", 4'hf, {diag_en, lf_state})
    wr_reg(`LFSC_A_STATE, 16'h0000);
    $display("t_states done");
  endtask
  task automatic t_ring_tone();
    int off_n;
    wr_reg(`LFSC_A_STATE, {13'h0, `LFSC_ST_RINGING});
    wr_reg(`LFSC_A_RING_CAD, 16'h0100);
    for (logic [1:0] m = 0; m < 3; m++) begin
      wr_reg(`LFSC_A_RING, {12'h0, m[0], ~m[0], m});
      tick(3);
      `LFSC_CHK("ring_mode", m, ring_mode)
      `LFSC_CHK("ring_shape", ~m[0], ring_trap)
      `LFSC_CHK("ring_dc", {1'b1, m[0]}, {ring_en, ring_dc})
      `LFSC_CHK("ring_both", 3'h7, {ring_en, tip_oe, ring_oe})
    end
    // A real cadence must show both bursts and pauses within a full period
    wr_reg(`LFSC_A_RING_CAD, 16'h0101);
    off_n = 0;
    repeat (1024) begin
      tick(1);
      off_n += !ring_en;
    end
    `LFSC_CHK("ring_cadence", 1'b1, off_n > 0 && off_n < 1024)
    wr_reg(`LFSC_A_RING_FRQ, 16'h5a3c);
    wr_reg(`LFSC_A_POL, 16'h00c3);
    wr_reg(`LFSC_A_TONE0, 16'h1234);
    wr_reg(`LFSC_A_TONE1, 16'hfedc);
    wr_reg(`LFSC_A_TONE_CTL, 16'h0007);
    tick(3);
    `LFSC_CHK("ring_freq", 16'h5a3c, ring_freq)
    `LFSC_CHK("pol_ramp", 8'hc3, pol_ramp)
    `LFSC_CHK("tones", {16'h1234, 16'hfedc, 3'h7}, {tone0, tone1, tone_en, tone_tx})
    wr_reg(`LFSC_A_TONE_CTL, 16'h0001);
    tick(3);
    `LFSC_CHK("tone_rx", 3'h2, {tone_en, tone_tx})
    wr_reg(`LFSC_A_STATE, 16'h0000);
    $display("t_ring_tone done");
  endtask
  // Each fault source in turn; code 3 is the high sensor with the 200 limit chosen
  task automatic t_faults();
    wr_reg(`LFSC_A_MASK, 16'h0004);
    for (int k = 0; k < 5; k++) begin
      wr_reg(`LFSC_A_THERM, {15'h0, k >= 3});
      if (k == 4) wr_reg(`LFSC_A_MASK, 16'h0000);
      wr_reg(`LFSC_A_STATE, 16'h0001);
      wr_reg(`LFSC_A_IRQ, 16'h000f);
      tick(3);
      @(posedge clk) fault <= (k == 4) ? 4'h4 : 4'(1 << k);
      tick(8);
      `LFSC_CHK("fault_state", (k == 4) ? 3'h1 : 3'h0, lf_state)
      `LFSC_CHK("alarm_irq", k < 4, irq)
      `LFSC_CHK("lowpwr", k == 2 || k == 3, lowpwr)
      wr_reg(`LFSC_A_STATE, 16'h0001);
      tick(3);
      `LFSC_CHK("fault_wins", k == 4, lf_state == 3'h1)
      @(posedge clk) fault <= 4'h0;
      tick(4);
      rd_reg(`LFSC_A_STATUS);
      `LFSC_CHK("therm_hold", k == 2 || k == 3, rd_val[3])
      tick(16);
      `LFSC_CHK("stay_open", k == 4, lf_state == 3'h1)
    end
    $display("t_faults done");
  endtask
  // Hysteresis and debounce of one detector: 0 loop closure, 1 ground key
  task automatic t_detect(input int g);
    wr_reg(g ? `LFSC_A_GK_THR : `LFSC_A_LC_THR, 16'h4020);
    wr_reg(`LFSC_A_DEB, 16'h0404);
    wr_reg(`LFSC_A_MASK, 16'h0003);
    wr_reg(`LFSC_A_STATE, 16'h0001);
    tick(20);
    wr_reg(`LFSC_A_IRQ, 16'h000f);
    drive(g, 16'h5000);
    drive(g, 16'h0000);
    tick(12);
    rd_reg(`LFSC_A_STATUS);
    `LFSC_CHK("glitch", 1'b0, rd_val[g])
    drive(g, 16'h5000);
    rd_reg(`LFSC_A_STATUS);
    `LFSC_CHK("early", 1'b0, rd_val[g])
    tick(12);
    rd_reg(`LFSC_A_STATUS);
    `LFSC_CHK("set", 1'b1, rd_val[g])
    rd_reg(`LFSC_A_IRQ);
    `LFSC_CHK("flag", 2'h3, {irq, rd_val[g]})
    wr_reg(`LFSC_A_IRQ, 16'h000f);
    drive(g, 16'h3000);
    tick(12);
    rd_reg(`LFSC_A_STATUS);
    `LFSC_CHK("hyst", 2'h2, {rd_val[g], irq})
    drive(g, 16'h1000);
    tick(12);
    rd_reg(`LFSC_A_STATUS);
    `LFSC_CHK("clear", 2'h1, {rd_val[g], irq})
    $display("t_detect done");
  endtask
  // All sixteen row and column pairs must give sixteen distinct digits
  task automatic t_dtmf();
    logic [15:0] seen;
    seen = 16'h0;
    for (int r = 0; r < 4; r++)
      for (int c = 0; c < 4; c++) begin
        @(posedge clk);
        row <= 2'(r);
        col <= 2'(c);
        tone_on <= 1'b1;
        tick(8);
        rd_reg(`LFSC_A_STATUS);
        `LFSC_CHK("dtmf_valid", 1'b1, rd_val[8])
        seen[rd_val[7:4]] = 1'b1;
        @(posedge clk) tone_on <= 1'b0;
        tick(8);
      end
    `LFSC_CHK("dtmf_digits", 16'hffff, seen)
    $display("t_dtmf done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_states();
    t_ring_tone();
    t_faults();
    t_detect(0);
    t_detect(1);
    t_dtmf();
    finish_test();
  end
endmodule // tb_lfsc_core
